// [bench/dsc_sva.sv]
// Port-level assertions for the display sequence controller
`timescale 1ns/1ps
module dsc_sva (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic SWEEP_GATE_FIRST_N,
    input wire logic READOUT_REQUEST,
    input wire logic READOUT_BLANK_IN,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_BVALID,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic HORIZ_SEL_A_N,
    input wire logic HORIZ_SEL_B_N,
    input wire logic TRIG_SRC_A_BIT0,
    input wire logic TRIG_SRC_A_BIT1,
    input wire logic TRIG_SRC_A_BIT2,
    input wire logic HOLDOFF_OUT,
    input wire logic BLANK_OUT,
    input wire logic READOUT_ACTIVE_N
);
    // ------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    wire [2:0] src = {TRIG_SRC_A_BIT2, TRIG_SRC_A_BIT1, TRIG_SRC_A_BIT0};
    sequence sweep_end;
        !SWEEP_GATE_FIRST_N ##1 SWEEP_GATE_FIRST_N;
    endsequence
    // Slack covers the input synchronisers
    sequence ro_steady;
        (READOUT_REQUEST && $stable(READOUT_BLANK_IN)) [*6];
    endsequence
    holdoff_rise_a: assert property (sweep_end |-> ##[1:6] HOLDOFF_OUT)
        else $error("holdoff not raised after sweep");
    roa_low_a: assert property (sweep_end |-> ##[1:6] !READOUT_ACTIVE_N)
        else $error("readout active not low after sweep");
    roa_release_a: assert property ($fell(HOLDOFF_OUT) |->
        $past(READOUT_ACTIVE_N)) else $error("readout active at trigger");
    roa_sweep_a: assert property (!HOLDOFF_OUT [*2] |-> READOUT_ACTIVE_N)
        else $error("readout active in sweep");
    blank_follow_a: assert property (ro_steady |->
        BLANK_OUT == READOUT_BLANK_IN) else $error("blank not following");
    readout_sel_a: assert property (ro_steady |->
        HORIZ_SEL_A_N && HORIZ_SEL_B_N) else $error("no readout select");
    trig_src_a: assert property (!HOLDOFF_OUT && !$past(HOLDOFF_OUT)
        |-> $stable(src)) else $error("source moved during sweep");
    read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
        S_AXI_RVALID) else $error("read answer late");
    write_refused_a: assert property (S_AXI_BVALID |-> S_AXI_BRESP == 2'h2)
        else $error("write not refused");
endmodule
bind dsc_top dsc_sva dsc_sva_i (.*);

// [bench/dsc_sweep_model.sv]
// Sweep and trigger hardware model answering the holdoff line
`timescale 1ns/1ps
module dsc_sweep_model (
    input wire logic clk,
    input wire logic run,
    input wire logic holdoff,
    output logic gate_n,
    output logic trig_n
);
    int cnt = 0;
    logic armed = 1'h0;
    // holdoff high arms
    // Rearm only after holdoff seen high, so no retrigger in holdoff
    always_ff @(posedge clk) begin
        if (holdoff) begin
            armed <= 1'h1;
        end
        if (!run) begin
            cnt <= 0;
        end else if (cnt > 0) begin
            cnt <= (cnt == 50) ? 0 : cnt + 1;
        end else if (!holdoff && armed) begin
            cnt <= 1;
            armed <= 1'h0;
        end
    end
    assign trig_n = !(cnt >= 5);
    assign gate_n = !(cnt >= 7 && cnt < 50);
endmodule

// [bench/dsc_top_tb.sv]
// Self-checking bench for the display sequence controller
`timescale 1ns/1ps
`include "dsc_defs.svh"
module dsc_top_tb;
    logic CLK = 1'h0, SRST = 1'h1, CTRL_DATA = 1'h0, CTRL_CLK = 1'h0;
    logic STATUS_SHIFT_STROBE = 1'h0, SWEEP_GATE_SECOND_N = 1'h1;
    logic TRIG_STAT_SECOND_N = 1'h1, READOUT_REQUEST = 1'h0;
    logic READOUT_BLANK_IN = 1'h0, S_AXI_AWVALID = 1'h0;
    logic S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
    logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
    logic [4:0] S_AXI_AWADDR = 5'h00, S_AXI_ARADDR = 5'h00;
    logic [31:0] S_AXI_WDATA = 32'h0000_0000;
    logic [3:0] S_AXI_WSTRB = 4'h0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID, SWEEP_GATE_FIRST_N, TRIG_STAT_FIRST_N;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [31:0] S_AXI_RDATA, rd;
    logic VERT_SEL_1_N, VERT_SEL_2_N, VERT_SEL_3_N, VERT_SEL_4_N;
    logic HORIZ_SEL_A_N, HORIZ_SEL_B_N, TRIG_SRC_A_BIT0, TRIG_SRC_A_BIT1;
    logic TRIG_SRC_A_BIT2, TRIG_SRC_B_BIT0, TRIG_SRC_B_BIT1;
    logic TRIG_SRC_B_BIT2, HOLDOFF_OUT, DELAY_REF_SELECT, BLANK_OUT;
    logic STATUS_SERIAL_OUT, READOUT_ACTIVE_N, TRACE_SEPARATION_OUT;
    logic [7:0] INTENSITY_LEVEL;
    logic [1:0] rs;
    logic run = 1'h0;
    int fails = 0, tests_run = 0;
    localparam logic [54:0] WORD = {19'h5_1234, 8'h3C, 8'hA5, 4'h2,
        2'h0, 2'h3, 3'h6, 3'h3, 2'h2, 4'h5};

    dsc_top dsc_top_i (.*);
    dsc_sweep_model dsc_sweep_model_i (.clk(CLK), .run(run),
        .holdoff(HOLDOFF_OUT), .gate_n(SWEEP_GATE_FIRST_N),
        .trig_n(TRIG_STAT_FIRST_N));
    always #10 CLK = !CLK;

    task automatic chk(input logic [54:0] got, input logic [54:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic axi_rd(input logic [4:0] a);
        @(posedge CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'h1;
        S_AXI_RREADY <= 1'h1;
        do @(posedge CLK); while (S_AXI_ARREADY !== 1'h1);
        S_AXI_ARVALID <= 1'h0;
        while (S_AXI_RVALID !== 1'h1) @(posedge CLK);
        rd = S_AXI_RDATA;
        rs = S_AXI_RRESP;
        S_AXI_RREADY <= 1'h0;
    endtask
    task automatic axi_wr(input logic [4:0] a);
        logic aw, w;
        aw = 1'h0;
        w = 1'h0;
        @(posedge CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= 32'hFFFF_FFFF;
        S_AXI_WSTRB <= 4'hF;
        S_AXI_AWVALID <= 1'h1;
        S_AXI_WVALID <= 1'h1;
        S_AXI_BREADY <= 1'h1;
        while (!(aw && w)) begin
            @(posedge CLK);
            if (!aw && S_AXI_AWREADY) begin
                aw = 1'h1;
                S_AXI_AWVALID <= 1'h0;
            end
            if (!w && S_AXI_WREADY) begin
                w = 1'h1;
                S_AXI_WVALID <= 1'h0;
            end
        end
        while (S_AXI_BVALID !== 1'h1) @(posedge CLK);
        rs = S_AXI_BRESP;
        S_AXI_BREADY <= 1'h0;
    endtask
    // Link clock stands still between strings
    task automatic load(input logic [54:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge CLK);
            CTRL_DATA <= v[i];
            repeat (2) @(posedge CLK);
            CTRL_CLK <= !CTRL_CLK;
            @(posedge CLK);
        end
        // Let the last edge clear the synchronisers
        repeat (3) @(posedge CLK);
    endtask
    task automatic t_status();
        @(posedge CLK);
        SWEEP_GATE_SECOND_N <= 1'h0;
        TRIG_STAT_SECOND_N <= 1'h0;
        repeat (4) @(posedge CLK);
        for (int i = 0; i < 4; i++) begin
            STATUS_SHIFT_STROBE <= 1'h1;
            repeat (6) @(posedge CLK);
            chk(STATUS_SERIAL_OUT, i[0] ? 1'h0 : 1'h1);
            STATUS_SHIFT_STROBE <= 1'h0;
            repeat (6) @(posedge CLK);
        end
        SWEEP_GATE_SECOND_N <= 1'h1;
        TRIG_STAT_SECOND_N <= 1'h1;
    endtask
    task automatic t_load();
        load(WORD, 55);
        axi_rd(`DSC_OFF_CTL0);
        chk(rd, WORD[31:0]);
        axi_rd(`DSC_OFF_CTL1);
        chk(rd, WORD[54:32]);
        load(~WORD, 30);
        chk({HOLDOFF_OUT, BLANK_OUT}, 2'h3);
        axi_rd(`DSC_OFF_CTL0);
        chk(rd, WORD[31:0]);
        load(~WORD >> 30, 25);
        axi_rd(`DSC_OFF_CTL0);
        chk(rd, 32'(~WORD[31:0]));
        load(WORD, 55);
        axi_wr(`DSC_OFF_CTL0);
        chk(rs, 2'h2);
        axi_rd(5'h14);
        chk({rs, rd}, 34'h2_0000_0000);
    endtask
    task automatic t_sweep();
        @(posedge CLK);
        run <= 1'h1;
        while (SWEEP_GATE_FIRST_N !== 1'h0) @(posedge CLK);
        repeat (8) @(posedge CLK);
        chk(HOLDOFF_OUT, 1'h0);
        chk({VERT_SEL_4_N, VERT_SEL_3_N, VERT_SEL_2_N, VERT_SEL_1_N,
            HORIZ_SEL_B_N, HORIZ_SEL_A_N},
            6'(~{WORD[3:0], WORD[5:4]}));
        chk({TRIG_SRC_B_BIT2, TRIG_SRC_B_BIT1, TRIG_SRC_B_BIT0,
            TRIG_SRC_A_BIT2, TRIG_SRC_A_BIT1, TRIG_SRC_A_BIT0},
            WORD[11:6]);
        chk({TRACE_SEPARATION_OUT, DELAY_REF_SELECT}, WORD[13:12]);
        chk(INTENSITY_LEVEL, WORD[27:20]);
        while (SWEEP_GATE_FIRST_N !== 1'h1) @(posedge CLK);
        run <= 1'h0;
        repeat (8) @(posedge CLK);
        chk({HOLDOFF_OUT, READOUT_ACTIVE_N, HORIZ_SEL_A_N, HORIZ_SEL_B_N},
            4'hB);
        chk(INTENSITY_LEVEL, WORD[35:28]);
    endtask
    task automatic t_readout();
        @(posedge CLK);
        READOUT_REQUEST <= 1'h1;
        READOUT_BLANK_IN <= 1'h1;
        repeat (8) @(posedge CLK);
        chk({BLANK_OUT, HORIZ_SEL_A_N, HORIZ_SEL_B_N}, 3'h7);
        READOUT_BLANK_IN <= 1'h0;
        repeat (8) @(posedge CLK);
        chk({BLANK_OUT, READOUT_ACTIVE_N}, 2'h0);
        READOUT_REQUEST <= 1'h0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------
    initial begin
        repeat (16) @(posedge CLK);
        chk({VERT_SEL_1_N, VERT_SEL_2_N, VERT_SEL_3_N, VERT_SEL_4_N,
            HORIZ_SEL_A_N, HORIZ_SEL_B_N, HOLDOFF_OUT, BLANK_OUT,
            READOUT_ACTIVE_N}, 9'h1FF);
        SRST <= 1'h0;
        t_status();
        t_load();
        t_sweep();
        t_readout();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        tally_and_finish();
    end
endmodule

// [common/dsc_defs.svh]
// Offsets, field positions, reset values and timing counts for the sequencer
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH
`define DSC_CTRL_BITS 55
`define DSC_AXI_AW 5
`define DSC_OFF_CTL0 5'h00
`define DSC_OFF_CTL1 5'h04
`define DSC_OFF_STAT 5'h08
`define DSC_OFF_HOLD 5'h0C
`define DSC_OFF_SWP 5'h10
// Control word fields
`define DSC_F_VSEL 0
`define DSC_F_HSEL 4
`define DSC_F_TSRCA 6
`define DSC_F_TSRCB 9
`define DSC_F_DLY 12
`define DSC_F_TRSEP 13
`define DSC_F_CHOP 14
`define DSC_F_PANEL 15
`define DSC_F_HOLDN 16
`define DSC_F_DI 20
`define DSC_F_ROI 28
`define DSC_F_RSV 36
// Holdoff ramp period and readout release margin
`define DSC_RAMP_NS 2000
`define DSC_RAMP_CYC ((`DSC_RAMP_NS + 19) / 20)
`define DSC_ROA_MARGIN_NS 1000
`define DSC_ROA_MARGIN_CYC ((`DSC_ROA_MARGIN_NS + 19) / 20)
`define DSC_CTRL_RST 55'h00_0000_0000_0000
`endif

// [common/dsc_pkg.sv]
// Types shared by the display sequence controller
package dsc_pkg;
    typedef enum logic [1:0] {
        DSC_SWEEP = 2'b00,
        DSC_HOLD = 2'b01,
        DSC_READOUT = 2'b10
    } dsc_state_t;
endpackage

// [src/dsc_top.sv]
// Display sequence controller with serial control and status ports
// Contract
// - Shift 55-bit control string in, one bit per control clock edge.
// - Control word split into fields, each driving one function.
// - Four active-low vertical selects pick channel, sum or readout.
// - Two active-low horizontal selects pick sweeps, X-Y or readout.
// - Three source lines per trigger pick trigger source.
// - Holdoff output covers sweep recovery and panel change settling.
// - Delay select routes reference zero or one to sweeps.
// - Gate and trigger status shifted out, one bit per strobe.
// - Intensity level set by readout, display and compensation values; no compensation value here, only readout and display fields.
// - Blank during chop switching, readout transitions, panel changes.
// - Readout mode entered at first sweep end or readout request.
// - In readout mode blanking follows readout blank input.
// - Readout active low from start of post-sweep holdoff.
// - Readout active high again before holdoff ends; on leaving request-entered readout it rises one clock after holdoff falls.
// - Trace separation enabled for alternate and delta displays.
// - Trigger sources change only during holdoff.
// - Holdoff low when satisfied, high after first gate rises.
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "dsc_defs.svh"
module dsc_top
import dsc_pkg::*;
#(
    parameter int CTRL_BITS = `DSC_CTRL_BITS
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic CTRL_DATA,
    input wire logic CTRL_CLK,
    input wire logic STATUS_SHIFT_STROBE,
    input wire logic SWEEP_GATE_FIRST_N,
    input wire logic SWEEP_GATE_SECOND_N,
    input wire logic TRIG_STAT_FIRST_N,
    input wire logic TRIG_STAT_SECOND_N,
    input wire logic READOUT_REQUEST,
    input wire logic READOUT_BLANK_IN,
    input wire logic [4:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [4:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic VERT_SEL_1_N,
    output logic VERT_SEL_2_N,
    output logic VERT_SEL_3_N,
    output logic VERT_SEL_4_N,
    output logic HORIZ_SEL_A_N,
    output logic HORIZ_SEL_B_N,
    output logic TRIG_SRC_A_BIT0,
    output logic TRIG_SRC_A_BIT1,
    output logic TRIG_SRC_A_BIT2,
    output logic TRIG_SRC_B_BIT0,
    output logic TRIG_SRC_B_BIT1,
    output logic TRIG_SRC_B_BIT2,
    output logic HOLDOFF_OUT,
    output logic DELAY_REF_SELECT,
    output logic STATUS_SERIAL_OUT,
    output logic [7:0] INTENSITY_LEVEL,
    output logic BLANK_OUT,
    output logic READOUT_ACTIVE_N,
    output logic TRACE_SEPARATION_OUT
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [9:0] sync1, sync2, prev, next_sync1;
    always_comb begin
        next_sync1 = {READOUT_BLANK_IN, READOUT_REQUEST, TRIG_STAT_SECOND_N,
            TRIG_STAT_FIRST_N, SWEEP_GATE_SECOND_N, SWEEP_GATE_FIRST_N,
            STATUS_SHIFT_STROBE, CTRL_CLK, CTRL_DATA, 1'b0};
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sync1 <= 10'h0F0;
            sync2 <= 10'h0F0;
            prev <= 10'h0F0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= sync1;
            prev <= sync2;
        end
    end
    logic s_data, cc_edge, tss_rise, sga_n, sga_rise, readout_request, readout_blank_in;
    assign s_data = sync2[1];
    // Either control clock edge shifts one bit
    assign cc_edge = sync2[2] ^ prev[2];
    assign tss_rise = sync2[3] & ~prev[3];
    assign sga_n = sync2[4];
    assign sga_rise = sync2[4] & ~prev[4];
    assign readout_request = sync2[8];
    assign readout_blank_in = sync2[9];

    // ------------------------------------------------------------
    // Serial control load
    // ------------------------------------------------------------
    logic [CTRL_BITS-1:0] shreg, ctrl, next_shreg, next_ctrl;
    logic [5:0] bitcnt, next_bitcnt;
    logic panel_chg, next_panel_chg;
    dsc_state_t state, next_state;
    logic [15:0] tcnt, next_tcnt, hold_cyc;
    always_comb begin
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_ctrl = ctrl;
        next_panel_chg = panel_chg;
        if (cc_edge) begin
            next_shreg = {s_data, shreg[CTRL_BITS-1:1]};
            next_panel_chg = 1'b1;
            if (bitcnt == 6'(CTRL_BITS - 1)) begin
                next_bitcnt = 6'h00;
                next_ctrl = {s_data, shreg[CTRL_BITS-1:1]};
            end else begin
                next_bitcnt = bitcnt + 6'h01;
            end
        end else if (bitcnt == 6'h00 && tcnt == hold_cyc - 16'h0001) begin
            next_panel_chg = 1'b0;
        end
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            shreg <= `DSC_CTRL_RST;
            ctrl <= `DSC_CTRL_RST;
            bitcnt <= 6'h00;
            panel_chg <= 1'b0;
        end else begin
            shreg <= next_shreg;
            ctrl <= next_ctrl;
            bitcnt <= next_bitcnt;
            panel_chg <= next_panel_chg;
        end
    end

    // ------------------------------------------------------------
    // Sequencer: sweep, holdoff and readout
    // ------------------------------------------------------------
    logic [3:0] ramps, next_ramps, ramp_goal;
    logic [5:0] trig_src, next_trig_src;
    function automatic logic [3:0] hold_ramps(input logic [3:0] field);
        hold_ramps = (field < 4'h2) ? 4'h2 : field;
    endfunction
    // holdoff length from ramp count field, at least two ramps
    assign ramp_goal = hold_ramps(ctrl[`DSC_F_HOLDN +: 4]);
    assign hold_cyc = 16'(`DSC_RAMP_CYC);
    always_comb begin
        next_state = state;
        next_tcnt = tcnt;
        next_ramps = ramps;
        next_trig_src = trig_src;
        case (state)
            DSC_SWEEP: begin
                if (sga_rise) begin
                    next_state = DSC_HOLD;
                    next_tcnt = 16'h0000;
                    next_ramps = 4'h0;
                end
            end
            DSC_HOLD: begin
                if (tcnt == hold_cyc - 16'h0001) begin
                    next_tcnt = 16'h0000;
                    next_ramps = (ramps == 4'hF) ? ramps : ramps + 4'h1;
                end else begin
                    next_tcnt = tcnt + 16'h0001;
                end
                next_trig_src = ctrl[`DSC_F_TSRCA +: 6];
                if (ramps >= ramp_goal && !panel_chg && !readout_request) begin
                    next_state = DSC_SWEEP;
                end
            end
            DSC_READOUT: begin
                if (!readout_request) begin
                    next_state = DSC_SWEEP;
                end
            end
            default: next_state = DSC_SWEEP;
        endcase
        if (state == DSC_SWEEP && readout_request && sga_n && !sga_rise) begin
            next_state = DSC_READOUT;
        end
        // panel change restarts the settling holdoff
        if (cc_edge) begin
            next_state = DSC_HOLD;
            next_tcnt = 16'h0000;
            next_ramps = 4'h0;
        end
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state <= DSC_HOLD;
            tcnt <= 16'h0000;
            ramps <= 4'h0;
            trig_src <= 6'h00;
        end else begin
            state <= next_state;
            tcnt <= next_tcnt;
            ramps <= next_ramps;
            trig_src <= next_trig_src;
        end
    end

    // ------------------------------------------------------------
    // Display outputs
    // ------------------------------------------------------------
    logic ro_mode, hold_end_near, next_blank, next_roa_n;
    logic [5:0] next_vh;
    logic [7:0] next_int;
    assign ro_mode = (state != DSC_SWEEP);
    // release before the last ramp finishes
    assign hold_end_near = (ramps >= ramp_goal) ||
        ((ramps == ramp_goal - 4'h1) &&
        (tcnt >= hold_cyc - 16'(`DSC_ROA_MARGIN_CYC)));
    always_comb begin
        // fields drive selects, readout forces all high
        next_vh = ro_mode ? 6'h3F : ~ctrl[`DSC_F_VSEL +: 6];
        next_int = ro_mode ? ctrl[`DSC_F_ROI +: 8] : ctrl[`DSC_F_DI +: 8];
        next_blank = panel_chg | (ro_mode ? readout_blank_in :
            (ctrl[`DSC_F_CHOP] & cc_edge) | ctrl[`DSC_F_PANEL]);
        next_roa_n = !((state == DSC_HOLD && !hold_end_near) ||
            state == DSC_READOUT);
    end
    logic [7:0] stat_sh, next_stat_sh;
    always_comb begin
        next_stat_sh = stat_sh;
        if (tss_rise) begin
            if (stat_sh[7:4] == 4'h0) begin
                next_stat_sh = {4'hF, sync2[7:4]};
            end else begin
                next_stat_sh = {1'b0, stat_sh[7:1]};
            end
        end
    end
    always_ff @(posedge CLK) begin
        if (SRST) begin
            {HORIZ_SEL_B_N, HORIZ_SEL_A_N, VERT_SEL_4_N, VERT_SEL_3_N,
                VERT_SEL_2_N, VERT_SEL_1_N} <= 6'h3F;
            INTENSITY_LEVEL <= 8'h00;
            BLANK_OUT <= 1'b1;
            READOUT_ACTIVE_N <= 1'b1;
            stat_sh <= 8'h00;
        end else begin
            {HORIZ_SEL_B_N, HORIZ_SEL_A_N, VERT_SEL_4_N, VERT_SEL_3_N,
                VERT_SEL_2_N, VERT_SEL_1_N} <= next_vh;
            INTENSITY_LEVEL <= next_int;
            BLANK_OUT <= next_blank;
            READOUT_ACTIVE_N <= next_roa_n;
            stat_sh <= next_stat_sh;
        end
    end
    assign STATUS_SERIAL_OUT = stat_sh[0];
    assign {TRIG_SRC_B_BIT2, TRIG_SRC_B_BIT1, TRIG_SRC_B_BIT0,
        TRIG_SRC_A_BIT2, TRIG_SRC_A_BIT1, TRIG_SRC_A_BIT0} = trig_src;
    // holdoff low only in sweep state
    assign HOLDOFF_OUT = (state != DSC_SWEEP);
    assign DELAY_REF_SELECT = ctrl[`DSC_F_DLY];
    assign TRACE_SEPARATION_OUT = ctrl[`DSC_F_TRSEP];

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_h, w_h, bv, rv;
    logic [31:0] rd;
    logic [1:0] rr;
    assign S_AXI_AWREADY = !aw_h && !bv;
    assign S_AXI_WREADY = !w_h && !bv;
    assign S_AXI_ARREADY = !rv;
    assign S_AXI_BVALID = bv;
    assign S_AXI_BRESP = 2'b10;
    assign S_AXI_RVALID = rv;
    assign S_AXI_RDATA = rd;
    assign S_AXI_RRESP = rr;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            aw_h <= 1'b0;
            w_h <= 1'b0;
            bv <= 1'b0;
            rv <= 1'b0;
            rd <= 32'h0000_0000;
            rr <= 2'b00;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_h <= 1'b1;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_h <= 1'b1;
            end
            if (aw_h && w_h) begin
                aw_h <= 1'b0;
                w_h <= 1'b0;
                bv <= 1'b1;
            end
            if (bv && S_AXI_BREADY) begin
                bv <= 1'b0;
            end
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                rv <= 1'b1;
                rr <= 2'b00;
                case (S_AXI_ARADDR)
                    `DSC_OFF_CTL0: rd <= ctrl[31:0];
                    `DSC_OFF_CTL1: rd <= {9'h000, ctrl[CTRL_BITS-1:32]};
                    `DSC_OFF_STAT: rd <= {24'h00_0000, stat_sh};
                    `DSC_OFF_HOLD: rd <= {24'h00_0000, ramps, 2'b00, state};
                    `DSC_OFF_SWP: rd <= {26'h000_0000, trig_src};
                    default: begin
                        rd <= 32'h0000_0000;
                        rr <= 2'b10;
                    end
                endcase
            end
            if (rv && S_AXI_RREADY) begin
                rv <= 1'b0;
            end
        end
    end
endmodule
